// >>> design/serial_pkg.sv
// Constants shared by the asynchronous serial transceiver: register map, fields, reset values.
package serial_pkg;
    // Register byte offsets on the AXI4-Lite bus.
    localparam logic [7:0] DATA_OFS = 8'h00; // Write: transmit holding, read: receive holding.
    localparam logic [7:0] FMT_OFS = 8'h04; // Line format register.
    localparam logic [7:0] LSR_OFS = 8'h08; // Line status register, read only.
    localparam logic [7:0] MCR_OFS = 8'h0C; // Modem control register.
    localparam logic [7:0] BAUD_OFS = 8'h10; // Baud divisor and clock output select.
    localparam logic [7:0] MSR_OFS = 8'h14; // Modem status register, read only.
    ////////////////////////////////////////////////////////////////////////////////
    // Line format fields.
    localparam int FMT_LEN_LSB = 0; // Two bits: data length minus five.
    localparam int FMT_PEN = 2; // Parity enable.
    localparam int FMT_ODD = 3; // Odd parity when set.
    localparam int FMT_STOP2 = 4; // Two stop bits when set.
    localparam int FMT_TXEN = 5; // Transmitter enable.
    localparam logic [7:0] FMT_RESET = 8'h23; // Eight bits, no parity, one stop, enabled.
    // Line status fields.
    localparam int LSR_PERR = 0;
    localparam int LSR_FERR = 1;
    localparam int LSR_OERR = 2;
    localparam int LSR_BRK = 3;
    localparam int LSR_READY = 4;
    localparam int LSR_TBE = 5;
    localparam int LSR_TC = 6;
    // Modem control fields.
    localparam int MCR_RTS = 0;
    localparam int MCR_DTR = 1;
    localparam int MCR_MODE_LSB = 2; // Two bits of operating mode.
    localparam int MCR_REN = 4; // Receiver enable.
    localparam int MCR_MIEN = 5; // Modem change interrupt enable.
    localparam int MCR_RIEN = 6; // Receive ready interrupt enable.
    localparam int MCR_GIE = 7; // Global interrupt enable.
    localparam logic [7:0] MCR_RESET = 8'h00;
    // Modem status fields.
    localparam int MSR_CTS_CHG = 0;
    localparam int MSR_DSR_CHG = 1;
    localparam int MSR_CTS_LVL = 4;
    localparam int MSR_DSR_LVL = 5;
    // Baud register fields.
    localparam int BAUD_COSEL = 16; // 1: baud clock on clock_output, 0: oscillator copy.
    localparam logic [15:0] BAUD_DIV_RESET = 16'h0036; // 16x tick divisor after reset.
    // Bit timing in 16x ticks.
    localparam logic [3:0] TICK_MID = 4'h7;
    localparam logic [3:0] TICK_LAST = 4'hF;
    // AXI responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {MODE_NORMAL, MODE_LOOP, MODE_ECHO, MODE_BREAK} mode_type;
endpackage : serial_pkg

// >>> design/serial_core.sv
// Asynchronous serial transceiver with AXI4-Lite register access.
// How it works
// - Request-to-send output goes low when its control bit is 1, high otherwise.
// - Serial input high is a mark (1), low is a space (0).
// - Serial input pin is ignored in loop test mode and during reset.
// - Serial output sits at mark when idle, disabled, clear-to-send false or looping.
// - Transmit buffer empty rises on transfer to the shifter and on reset.
// - Transmit buffer empty drops as soon as the host writes a character.
// - Host writes land in the register picked by the address.
// - Clock output shows the oscillator copy or the 8x baud clock, toggled on each 16x tick, by selection.
// - Five to eight bit characters pass holding then shift register, back to back.
// - Receiver shifts bits in, then moves the character to a readable holding register.
// - Receiver reports parity, overrun, framing errors and break characters.
// - Modem control selects normal, loop test, echo or transmit break mode.
// - Modem control holds interrupt enables and drives request-to-send and terminal-ready.
// - Modem status records changes of clear-to-send and data-set-ready and their levels.
// - Line format sets data bits, parity and stop bits.
// - Line status always shows the present status conditions.
// - Normal mode has no internal path between serial input and output.
// - Transmit break mode sends frames of all zeros.
// - Echo mode forwards the serial input to the serial output.
// - Echo mode keeps host characters off the serial output.
// - Loop test mode routes transmit data to the receiver, never to the pin.
// - Loop test mode ignores the serial input pin.
// - Clear-to-send dropping mid-character lets that character finish.
// - Receive ready rises on a new character, clears on reading it or reset.
// - Interrupt output stays low while the global interrupt enable is clear.
// - Reset clears line status except transmit complete and buffer empty, which set.
`timescale 1ns/1ps
module serial_core (
    input wire logic aclk, // System clock, 100 MHz.
    input wire logic aresetn, // Synchronous reset, active low.
    input wire logic [7:0] awaddr, // Write address.
    input wire logic awvalid, // Write address valid.
    output logic awready, // Write address ready.
    input wire logic [31:0] wdata, // Write data.
    input wire logic [3:0] wstrb, // Write byte strobes.
    input wire logic wvalid, // Write data valid.
    output logic wready, // Write data ready.
    output logic [1:0] bresp, // Write response.
    output logic bvalid, // Write response valid.
    input wire logic bready, // Write response ready.
    input wire logic [7:0] araddr, // Read address.
    input wire logic arvalid, // Read address valid.
    output logic arready, // Read address ready.
    output logic [31:0] rdata, // Read data.
    output logic [1:0] rresp, // Read response.
    output logic rvalid, // Read data valid.
    input wire logic rready, // Read data ready.
    input wire logic oscillator_input, // Oscillator level, sampled on aclk.
    input wire logic serial_in, // Serial line input.
    input wire logic cts_n, // Clear to send, active low.
    input wire logic dsr_n, // Data set ready, active low.
    output logic serial_out, // Serial line output.
    output logic rts_n, // Request to send, active low.
    output logic dtr_n, // Data terminal ready, active low.
    output logic tx_buffer_empty_flag, // Transmit holding register empty.
    output logic receive_ready, // Character waiting in receive holding register.
    output logic irq_output, // Interrupt request, active high.
    output logic clock_output // Oscillator copy or 8x baud clock.
);
    ////////////////////////////////////////////////////////////////////////////////
    // Bus slave state.
    logic aw_hold_q, w_hold_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic [7:0] fmt_q, mcr_q, rx_holding_register;
    logic [16:0] baud_q;
    logic [7:0] tx_holding_register;
    logic hold_full_q;

    // A write completes once both halves are held and no response is pending.
    wire wr_do = aw_hold_q && w_hold_q && !bvalid;
    wire ar_take = arvalid && arready;
    wire aw_d = wr_do ? 1'b0 : ((awvalid && awready) ? 1'b1 : aw_hold_q);
    wire w_d = wr_do ? 1'b0 : ((wvalid && wready) ? 1'b1 : w_hold_q);
    wire rvalid_d = ar_take ? 1'b1 : (rready ? 1'b0 : rvalid);
    wire wr_thr = wr_do && aw_addr_q == serial_pkg::DATA_OFS && w_strb_q[0];
    wire wr_fmt = wr_do && aw_addr_q == serial_pkg::FMT_OFS && w_strb_q[0];
    wire wr_mcr = wr_do && aw_addr_q == serial_pkg::MCR_OFS && w_strb_q[0];
    wire wr_baud = wr_do && aw_addr_q == serial_pkg::BAUD_OFS;
    wire wr_map = aw_addr_q inside {serial_pkg::DATA_OFS, serial_pkg::FMT_OFS,
        serial_pkg::LSR_OFS, serial_pkg::MCR_OFS, serial_pkg::BAUD_OFS, serial_pkg::MSR_OFS};
    wire rd_rbr = ar_take && araddr == serial_pkg::DATA_OFS;
    wire rd_lsr = ar_take && araddr == serial_pkg::LSR_OFS;
    wire rd_msr = ar_take && araddr == serial_pkg::MSR_OFS;
    wire serial_pkg::mode_type mode = serial_pkg::mode_type'(mcr_q[serial_pkg::MCR_MODE_LSB +: 2]);

    // Handshake flags; awready and wready are registered inverses of the next hold state, arready of the next rvalid.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            arready <= 1'b0;
            bvalid <= 1'b0;
            rvalid <= 1'b0;
        end else begin
            aw_hold_q <= aw_d;
            w_hold_q <= w_d;
            awready <= !aw_d;
            wready <= !w_d;
            arready <= !rvalid_d;
            rvalid <= rvalid_d;
            bvalid <= wr_do ? 1'b1 : (bready ? 1'b0 : bvalid);
        end
    end

    // Payload capture and response codes; unmapped addresses answer with a slave error.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            bresp <= serial_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) aw_addr_q <= awaddr;
            if (wvalid && wready) begin
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            if (wr_do) bresp <= wr_map ? serial_pkg::RESP_OKAY : serial_pkg::RESP_SLVERR;
        end
    end

    // Control registers written by software.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fmt_q <= serial_pkg::FMT_RESET;
            mcr_q <= serial_pkg::MCR_RESET;
            baud_q <= {1'b0, serial_pkg::BAUD_DIV_RESET};
        end else begin
            if (wr_fmt) fmt_q <= w_data_q[7:0];
            if (wr_mcr) mcr_q <= w_data_q[7:0];
            if (wr_baud && w_strb_q[0]) baud_q[7:0] <= w_data_q[7:0];
            if (wr_baud && w_strb_q[1]) baud_q[15:8] <= w_data_q[15:8];
            if (wr_baud && w_strb_q[2]) baud_q[16] <= w_data_q[16];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Input synchronizers; the first stage feeds only the second.
    logic [2:0] sync1_q, sync2_q;
    logic cts_prev_q, dsr_prev_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= 3'h7;
            sync2_q <= 3'h7;
        end else begin
            sync1_q <= {dsr_n, cts_n, serial_in};
            sync2_q <= sync1_q;
        end
    end
    wire rx_pin = sync2_q[0];
    wire cts_ok = !sync2_q[1];
    wire dsr_ok = !sync2_q[2];

    ////////////////////////////////////////////////////////////////////////////////
    // Baud generator: 16x tick pulse plus a square clock for the clock output.
    logic [15:0] bcnt_q;
    logic bclk_q;
    wire tick = bcnt_q >= baud_q[15:0] - 16'h0001 || baud_q[15:0] == 16'h0000;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bcnt_q <= 16'h0000;
            bclk_q <= 1'b0;
            clock_output <= 1'b0;
        end else begin
            bcnt_q <= tick ? 16'h0000 : bcnt_q + 16'h0001;
            if (tick) bclk_q <= !bclk_q;
            clock_output <= baud_q[serial_pkg::BAUD_COSEL] ? bclk_q : oscillator_input;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Transmitter: holding register, frame shifter and bit timing.
    logic [11:0] tx_shift_q;
    logic [3:0] tx_left_q, tx_tick_q;
    logic tx_busy_q, tx_line;
    wire [3:0] nbits = 4'h5 + {2'b00, fmt_q[serial_pkg::FMT_LEN_LSB +: 2]};
    wire pen = fmt_q[serial_pkg::FMT_PEN];
    wire [7:0] dmask = 8'hFF >> (4'h8 - nbits);
    wire [7:0] tdat = tx_holding_register & dmask;
    wire tpar = (^tdat) ^ fmt_q[serial_pkg::FMT_ODD];
    wire [11:0] tframe = (mode == serial_pkg::MODE_BREAK) ? 12'h000 :
        ((12'hFFF << (nbits + {3'b000, pen} + 4'h1)) |
        ({11'h000, pen & tpar} << (nbits + 4'h1)) | {3'b000, tdat, 1'b0});
    wire [3:0] tlen = nbits + {3'b000, pen} + 4'h2 + {3'b000, fmt_q[serial_pkg::FMT_STOP2]};
    wire tx_end = tx_busy_q && tick && tx_tick_q == serial_pkg::TICK_LAST && tx_left_q == 4'h1;
    // Loading right at the end of a frame keeps characters back to back.
    wire tx_load = hold_full_q && cts_ok && fmt_q[serial_pkg::FMT_TXEN] &&
        mode != serial_pkg::MODE_ECHO && (!tx_busy_q || tx_end);
    assign tx_line = tx_busy_q ? tx_shift_q[0] : 1'b1;

    // Holding register: a host write wins over a same-cycle transfer.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_holding_register <= 8'h00;
            hold_full_q <= 1'b0;
        end else begin
            if (wr_thr) tx_holding_register <= w_data_q[7:0];
            hold_full_q <= wr_thr ? 1'b1 : (tx_load ? 1'b0 : hold_full_q);
        end
    end

    // Shifter; clear-to-send is only checked before a frame, so a frame always ends.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_busy_q <= 1'b0;
            tx_shift_q <= 12'hFFF;
            tx_left_q <= 4'h0;
            tx_tick_q <= 4'h0;
        end else if (tx_load) begin
            tx_busy_q <= 1'b1;
            tx_shift_q <= tframe;
            tx_left_q <= tlen;
            tx_tick_q <= 4'h0;
        end else if (tx_busy_q && tick) begin
            tx_tick_q <= tx_tick_q + 4'h1;
            if (tx_tick_q == serial_pkg::TICK_LAST) begin
                tx_shift_q <= {1'b1, tx_shift_q[11:1]};
                tx_left_q <= tx_left_q - 4'h1;
                if (tx_left_q == 4'h1) tx_busy_q <= 1'b0;
            end
        end
    end

    // Pin selection by mode; echo repeats the synchronized input.
    always_ff @(posedge aclk) begin
        if (!aresetn) serial_out <= 1'b1;
        else if (mode == serial_pkg::MODE_LOOP) serial_out <= 1'b1;
        else if (mode == serial_pkg::MODE_ECHO) serial_out <= rx_pin;
        else serial_out <= tx_line;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Receiver: start detection, centre sampling and error checks.
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rx_state_type;
    rx_state_type rx_state_q;
    logic [3:0] rx_tick_q, rx_idx_q;
    logic [9:0] rx_shift_q;
    logic rx_prev_q, rx_done;
    logic perr_q, ferr_q, oerr_q, brk_q;
    wire rx_src = (mode == serial_pkg::MODE_LOOP) ? tx_line : rx_pin;
    wire rx_in = mcr_q[serial_pkg::MCR_REN] ? rx_src : 1'b1;
    wire [3:0] rx_last = nbits + {3'b000, pen};
    // The bit being sampled now is merged in, so the stop bit is seen on the final edge.
    wire [9:0] rx_word = rx_shift_q | ({9'h000, rx_in} << rx_idx_q);
    wire [7:0] rdat = rx_word[7:0] & dmask;
    wire rpar = rx_word[nbits];
    wire rstop = rx_word[rx_last];
    assign rx_done = rx_state_q == RX_BITS && tick && rx_tick_q == serial_pkg::TICK_LAST &&
        rx_idx_q == rx_last;

    // Bit timing state machine.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_state_q <= RX_IDLE;
            rx_prev_q <= 1'b1;
            rx_tick_q <= 4'h0;
            rx_idx_q <= 4'h0;
            rx_shift_q <= 10'h000;
        end else begin
            rx_prev_q <= rx_in;
            case (rx_state_q)
                RX_IDLE: begin
                    rx_tick_q <= 4'h0;
                    if (rx_prev_q && !rx_in) rx_state_q <= RX_START;
                end
                RX_START: begin
                    if (tick) rx_tick_q <= rx_tick_q + 4'h1;
                    if (tick && rx_tick_q == serial_pkg::TICK_MID) begin
                        rx_state_q <= rx_in ? RX_IDLE : RX_BITS;
                        rx_tick_q <= 4'h0;
                        rx_idx_q <= 4'h0;
                        rx_shift_q <= 10'h000;
                    end
                end
                RX_BITS: begin
                    if (tick) rx_tick_q <= rx_tick_q + 4'h1;
                    if (tick && rx_tick_q == serial_pkg::TICK_LAST) begin
                        rx_shift_q[rx_idx_q] <= rx_in;
                        rx_idx_q <= rx_idx_q + 4'h1;
                        if (rx_idx_q == rx_last) rx_state_q <= RX_IDLE;
                    end
                end
                default: rx_state_q <= RX_IDLE;
            endcase
        end
    end

    // Holding register and sticky status; a new event wins over a clearing read.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_holding_register <= 8'h00;
            receive_ready <= 1'b0;
            perr_q <= 1'b0;
            ferr_q <= 1'b0;
            oerr_q <= 1'b0;
            brk_q <= 1'b0;
        end else begin
            if (rx_done) rx_holding_register <= rdat;
            receive_ready <= rx_done ? 1'b1 : (rd_rbr ? 1'b0 : receive_ready);
            perr_q <= (rx_done && pen && (rpar != ((^rdat) ^ fmt_q[serial_pkg::FMT_ODD])))
                || (perr_q && !rd_lsr);
            ferr_q <= (rx_done && !rstop) || (ferr_q && !rd_lsr);
            oerr_q <= (rx_done && receive_ready && !rd_rbr) || (oerr_q && !rd_lsr);
            brk_q <= (rx_done && rdat == 8'h00 && !(pen && rpar) && !rstop)
                || (brk_q && !rd_lsr);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Modem status, modem outputs and interrupt.
    logic cts_chg_q, dsr_chg_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cts_prev_q <= 1'b0;
            dsr_prev_q <= 1'b0;
            cts_chg_q <= 1'b0;
            dsr_chg_q <= 1'b0;
            rts_n <= 1'b1;
            dtr_n <= 1'b1;
            irq_output <= 1'b0;
            tx_buffer_empty_flag <= 1'b1;
        end else begin
            cts_prev_q <= cts_ok;
            dsr_prev_q <= dsr_ok;
            cts_chg_q <= (cts_ok != cts_prev_q) || (cts_chg_q && !rd_msr);
            dsr_chg_q <= (dsr_ok != dsr_prev_q) || (dsr_chg_q && !rd_msr);
            rts_n <= !mcr_q[serial_pkg::MCR_RTS];
            dtr_n <= !mcr_q[serial_pkg::MCR_DTR];
            irq_output <= mcr_q[serial_pkg::MCR_GIE] &&
                ((mcr_q[serial_pkg::MCR_MIEN] && (cts_chg_q || dsr_chg_q)) ||
                (mcr_q[serial_pkg::MCR_RIEN] && receive_ready));
            tx_buffer_empty_flag <= !(wr_thr || (hold_full_q && !tx_load));
        end
    end

    // Read data mux; status views are live so software can poll them.
    logic [7:0] lsr_view, msr_view;
    assign lsr_view = {1'b0, !hold_full_q && !tx_busy_q, !hold_full_q, receive_ready,
        brk_q, oerr_q, ferr_q, perr_q};
    assign msr_view = {2'b00, dsr_ok, cts_ok, 2'b00, dsr_chg_q, cts_chg_q};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata <= 32'h0000_0000;
            rresp <= serial_pkg::RESP_OKAY;
        end else if (ar_take) begin
            rresp <= serial_pkg::RESP_OKAY;
            case (araddr)
                serial_pkg::DATA_OFS: rdata <= {24'h000000, rx_holding_register};
                serial_pkg::FMT_OFS: rdata <= {24'h000000, fmt_q};
                serial_pkg::LSR_OFS: rdata <= {24'h000000, lsr_view};
                serial_pkg::MCR_OFS: rdata <= {24'h000000, mcr_q};
                serial_pkg::BAUD_OFS: rdata <= {15'h0000, baud_q};
                serial_pkg::MSR_OFS: rdata <= {24'h000000, msr_view};
                default: begin
                    rdata <= 32'h0000_0000;
                    rresp <= serial_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions.
    sequence s_thr_write;
        wr_thr ##1 1'b1;
    endsequence
    a_rts_follows: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_mcr |-> ##2 rts_n == !$past(w_data_q[0], 2)) else $error("rts level wrong");
    a_tbe_drop: assert property (@(posedge aclk) disable iff (!aresetn)
        s_thr_write |-> !tx_buffer_empty_flag) else $error("buffer empty not cleared");
    a_tbe_rise: assert property (@(posedge aclk) disable iff (!aresetn)
        tx_load && !wr_thr |=> tx_buffer_empty_flag) else $error("buffer empty not set");
    a_loop_mark: assert property (@(posedge aclk) disable iff (!aresetn)
        mode == serial_pkg::MODE_LOOP |=> serial_out) else $error("loop mode drove line");
    a_echo_copy: assert property (@(posedge aclk) disable iff (!aresetn)
        mode == serial_pkg::MODE_ECHO |=> serial_out == $past(rx_pin)) else $error("no echo");
    a_break_low: assert property (@(posedge aclk) disable iff (!aresetn)
        tx_load && mode == serial_pkg::MODE_BREAK && !$rose(mcr_q[2]) ##1
        mode == serial_pkg::MODE_BREAK |=> !serial_out) else $error("break not low");
    a_ready_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_rbr && !rx_done |=> !receive_ready) else $error("ready not cleared");
    a_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        !mcr_q[serial_pkg::MCR_GIE] |=> !irq_output) else $error("irq while disabled");
    a_cts_block: assert property (@(posedge aclk) disable iff (!aresetn)
        !tx_busy_q && !cts_ok |=> !tx_busy_q) else $error("sent without clear to send");
    a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write response dropped");
endmodule : serial_core

// >>> verif/line_partner.sv
// Remote serial device model: rests the line at mark and captures 8N1 frames.
`timescale 1ns/1ps
module line_partner (
    input wire logic aclk, // System clock.
    input wire logic serial_out, // Line from the transceiver.
    output logic serial_in, // Line to the transceiver.
    output logic cts_n, // Clear to send, held true.
    output logic dsr_n, // Data set ready, held true.
    output logic [7:0] got_q // Last captured character.
);
    // Idle at mark so the receiver never sees a false start.
    initial begin
        serial_in = 1'b1;
        cts_n = 1'b0;
        dsr_n = 1'b0;
        got_q = 8'h00;
    end
    // Bits are sampled at their centres; a bit lasts 16 cycles with divisor zero.
    always begin
        @(negedge serial_out);
        repeat (8) @(posedge aclk);
        for (int i = 0; i < 8; i++) begin
            repeat (16) @(posedge aclk);
            got_q[i] = serial_out;
        end
        repeat (16) @(posedge aclk);
    end
endmodule : line_partner

// >>> verif/tb.sv
// Self-checking bench for the serial transceiver.
`timescale 1ns/1ps
module tb;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
    logic arready, rvalid, serial_in, cts_n, dsr_n, serial_out, rts_n, dtr_n, irq_output;
    logic tx_buffer_empty_flag, receive_ready, clock_output, oscillator_input;
    logic [7:0] awaddr, araddr, got;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rr;
    int miscompares = 0, cmp_count = 0, cycles = 0;
    serial_core uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .oscillator_input, .serial_in, .cts_n, .dsr_n, .serial_out, .rts_n, .dtr_n,
        .tx_buffer_empty_flag, .receive_ready, .irq_output, .clock_output);
    line_partner peer (.aclk, .serial_out, .serial_in, .cts_n, .dsr_n, .got_q(got));
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // A hang is cut short well past the thousand or so cycles the tests need.
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 8000) begin
            miscompares++;
            give_verdict();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Handshakes are judged at the rising edge; bready and rready stay high throughout.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1'b1; wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a);
        araddr <= a; arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd = rdata;
        rr = rresp;
    endtask : axi_rd
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    initial begin
        {awvalid, wvalid, arvalid, oscillator_input} = '0;
        bready = 1'b1;
        rready = 1'b1;
        {awaddr, araddr, wdata, wstrb} = '0;
        aresetn = 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check("tbe", tx_buffer_empty_flag, 1);
        check("rts", rts_n, 1);
        check("line", serial_out, 1);
        axi_rd(serial_pkg::LSR_OFS);
        check("status", rd, 32'h60);
        $display("reset test done");
        axi_wr(serial_pkg::MCR_OFS, 32'h03);
        @(posedge aclk);
        check("rts on", {rts_n, dtr_n}, 0);
        axi_wr(serial_pkg::MCR_OFS, 32'h00);
        @(posedge aclk);
        check("rts off", rts_n, 1);
        $display("modem control test done");
        axi_wr(serial_pkg::BAUD_OFS, 32'h0);
        axi_wr(serial_pkg::DATA_OFS, 32'hA5);
        repeat (100) if (tx_buffer_empty_flag !== 1'b1) @(posedge aclk);
        axi_wr(serial_pkg::DATA_OFS, 32'h3C);
        check("tbe low", tx_buffer_empty_flag, 0);
        repeat (400) @(posedge aclk);
        check("frame", got, 8'h3C);
        check("tbe high", tx_buffer_empty_flag, 1);
        $display("transmit test done");
        axi_wr(serial_pkg::MCR_OFS, 32'h14);
        axi_wr(serial_pkg::DATA_OFS, 32'h5A);
        repeat (400) if (receive_ready !== 1'b1) @(posedge aclk);
        check("ready", receive_ready, 1);
        axi_rd(serial_pkg::DATA_OFS);
        check("loop data", rd, 32'h5A);
        @(posedge aclk);
        check("ready clr", receive_ready, 0);
        check("pin quiet", got, 8'h3C);
        axi_rd(8'h1C);
        check("unmapped", rr, serial_pkg::RESP_SLVERR);
        $display("loop test done");
        axi_wr(serial_pkg::MCR_OFS, 32'h0C);
        axi_wr(serial_pkg::DATA_OFS, 32'hFF);
        repeat (300) @(posedge aclk);
        check("break frame", got, 8'h00);
        $display("break test done");
        give_verdict();
    end
endmodule : tb
